// ==== cic_chk.sv ====
// Purpose: Port-level checks for the CIC filter
// Assumes: Bound to the top module, one clock domain
// Notes: Mirrors CTRL writes to know the backpressure mode
`timescale 1ns/1ps
`default_nettype none
module cic_chk
  import cic_pkg::*;
#(
  parameter int OUT_W = DEF_OUT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic s_cfg_tvalid,
  input wire logic s_cfg_tready,
  input wire logic s_data_tready,
  input wire logic m_data_tvalid,
  input wire logic m_data_tready,
  input wire logic [OUT_W-1:0] m_data_tdata,
  input wire out_user_t m_data_tuser
);
  logic [CTRL_W-1:0] ctrl_q;
  logic done;
  logic bp;
  assign done = psel && penable && pready;
  assign bp = ctrl_q[CTRL_BP_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (done && pwrite && paddr == CTRL_ADDR) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end
  ////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rst; $rose(presetn) |-> !m_data_tvalid && !s_data_tready && !pready; endproperty
  a_rst: assert property (p_rst) else $error("output active at reset exit");
  property p_hold; bp && m_data_tvalid && !m_data_tready |=> m_data_tvalid
    && $stable(m_data_tdata) && $stable(m_data_tuser); endproperty
  a_hold: assert property (p_hold) else $error("output dropped while stalled");
  property p_gap; !bp && m_data_tvalid |=> !m_data_tvalid [*3]; endproperty
  a_gap: assert property (p_gap) else $error("outputs too close");
  property p_cfg; s_cfg_tvalid && s_cfg_tready |=> !s_cfg_tready; endproperty
  a_cfg: assert property (p_cfg) else $error("config ready stayed high");
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("bus ready too long");
  property p_err; done |-> pslverr == (paddr != CTRL_ADDR && paddr != STATUS_ADDR); endproperty
  a_err: assert property (p_err) else $error("wrong error response");
  property p_rd; done && !pwrite && paddr == CTRL_ADDR |-> prdata == 32'(ctrl_q); endproperty
  a_rd: assert property (p_rd) else $error("control readback wrong");
  property p_mark; m_data_tvalid |-> m_data_tuser.first_channel_marker
    && m_data_tuser.channel_index_field == '0; endproperty
  a_mark: assert property (p_mark) else $error("sideband wrong");
endmodule
bind cic_rate_change_filter cic_chk #(.OUT_W(OUT_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .s_cfg_tvalid(s_cfg_tvalid),
  .s_cfg_tready(s_cfg_tready), .s_data_tready(s_data_tready), .m_data_tvalid(m_data_tvalid),
  .m_data_tready(m_data_tready), .m_data_tdata(m_data_tdata), .m_data_tuser(m_data_tuser));
`default_nettype wire

// ==== cic_pkg.sv ====
// Purpose: Shared constants, types and growth math for the CIC filter
// Assumes: 32-bit APB register bus, one clock
// Notes: Growth helper serves elaboration and runtime shift selection
package cic_pkg;

  typedef enum logic {DECIMATE, INTERPOLATE} filter_mode_t;

  localparam int DEF_STAGES = 3;
  localparam int DEF_DIFF_DELAY = 1;
  localparam int DEF_IN_W = 16;
  localparam int DEF_OUT_W = 24;
  localparam int DEF_RATE_MAX = 8192;
  localparam int DEF_RATE_MIN = 4;
  localparam int DEF_RATE_INIT = 4;
  localparam int DEF_CHANNELS = 1;
  localparam int DEF_BUF_DEPTH = 2;
  localparam int MAX_CHANNELS = 16;
  localparam int MAX_GROWTH = 62;

  localparam int APB_AW = 8;
  localparam int CFG_W = 16;
  localparam int CHAN_IDX_W = 4;
  localparam int SHIFT_W = 8;

  localparam logic [APB_AW-1:0] CTRL_ADDR = 8'h00;
  localparam logic [APB_AW-1:0] STATUS_ADDR = 8'h04;
  localparam int CTRL_ROUND_BIT = 0;
  localparam int CTRL_BP_BIT = 1;
  localparam int CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
  localparam int STATUS_PEND_BIT = 16;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic first_channel_marker;
    logic [CHAN_IDX_W-1:0] channel_index_field;
  } out_user_t;

  // Bits of growth: clog2((rM)^N) or clog2((rM)^N / r)
  function automatic int growth_bits(filter_mode_t mode, int unsigned r, int n, int m);
    logic [63:0] p;
    int k;
    p = 64'h0000_0000_0000_0001;
    k = 0;
    for (int i = 0; i < n; i++) begin
      p = p * 64'(m);
      if (mode == DECIMATE || i > 0) begin
        p = p * 64'(r);
      end
    end
    for (int i = 0; i < 64; i++) begin
      if ((64'h0000_0000_0000_0001 << i) < p) begin
        k = i + 1;
      end
    end
    return k;
  endfunction

endpackage

// ==== cic_rate_change_filter.sv ====
// Purpose: CIC decimator or interpolator with stream ports and APB control
// Assumes: One clock pclk, async active-low presetn
// Notes: One sample per cycle through unrolled integrator and comb chains
//
// Functional notes
// - Full decimator width is growth plus input width
// - Full precision stages use maximum growth width
// - Limited decimator prunes stage bits toward output
// - Interpolator: comb, zero stuffing, then integrators
// - Interpolator stages full width; output only scaled
// - Narrow output truncates, or rounds when rounding on; full width keeps gain
// - Truncated output shifted by current rate growth
// - Full precision output is never gain normalized
// - One clock drives everything
// - One active-low reset clears everything except the input FIFO storage
// - Transfer only when valid and ready high
// - Sender holds valid and payload until ready; output only with backpressure on
// - Either side may wait any number of cycles
// - First channel output carries first channel marker
// - Every output carries its channel index
// - Rate captured only on config handshake
// - New rate applies at next first-channel input
// - Backpressure stalls output; input buffers samples
// - Decimator forwards every rate-th integrator output
// - Unstalled decimator outputs every rate cycles
// - Config ready low until new rate applied
`timescale 1ns/1ps
`default_nettype none
module cic_rate_change_filter
  import cic_pkg::*;
#(
  parameter filter_mode_t MODE = DECIMATE,
  parameter int STAGES = DEF_STAGES,
  parameter int DIFF_DELAY = DEF_DIFF_DELAY,
  parameter int IN_W = DEF_IN_W,
  parameter int OUT_W = DEF_OUT_W,
  parameter int RATE_MAX = DEF_RATE_MAX,
  parameter int RATE_MIN = DEF_RATE_MIN,
  parameter int RATE_INIT = DEF_RATE_INIT,
  parameter int CHANNELS = DEF_CHANNELS,
  parameter int BUF_DEPTH = DEF_BUF_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic s_data_tvalid,
  output logic s_data_tready,
  input wire logic [IN_W-1:0] s_data_tdata,
  input wire logic s_cfg_tvalid,
  output logic s_cfg_tready,
  input wire logic [CFG_W-1:0] s_cfg_tdata,
  output logic m_data_tvalid,
  input wire logic m_data_tready,
  output logic [OUT_W-1:0] m_data_tdata,
  output out_user_t m_data_tuser
);
  ////////////////////////////////////////////////////////////////////////////
  // Sizing
  localparam int GROW = growth_bits(MODE, RATE_MAX, STAGES, DIFF_DELAY);
  localparam int BM = GROW + IN_W;
  localparam int RW = $clog2(RATE_MAX + 1);
  localparam bit FULL = (OUT_W == BM);
  localparam int CW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

  if (STAGES < 1 || DIFF_DELAY < 1 || OUT_W < 1 || OUT_W > BM || IN_W < 2 ||
      CHANNELS < 1 || CHANNELS > MAX_CHANNELS || RATE_MIN < 2 ||
      RATE_MAX < RATE_MIN || RATE_INIT < RATE_MIN || RATE_INIT > RATE_MAX ||
      GROW > MAX_GROWTH || RW > CFG_W) begin : g_bad_cfg
    $error("cic_rate_change_filter parameters out of range");
  end

  function automatic logic [SHIFT_W-1:0] shift_for(input logic [RW-1:0] r);
    int s;
    s = growth_bits(MODE, int'(r), STAGES, DIFF_DELAY) + IN_W - OUT_W;
    if (FULL || s < 0) begin
      s = 0;
    end
    return SHIFT_W'(s);
  endfunction

  localparam logic [RW-1:0] RATE_RST = RW'(RATE_INIT);
  localparam logic [SHIFT_W-1:0] SHIFT_RST = shift_for(RW'(RATE_INIT));

  typedef enum logic {ST_IDLE, ST_EMIT} emit_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [BM-1:0] integ_q [STAGES][CHANNELS];
  logic [BM-1:0] dly_q [STAGES][CHANNELS][DIFF_DELAY];
  logic [BM-1:0] hold_q [CHANNELS];
  logic [BM-1:0] stage_mask [2*STAGES];
  logic [BM-1:0] int_new [STAGES];
  logic [BM-1:0] comb_in [STAGES];
  logic [BM-1:0] comb_new [STAGES];
  logic [BM-1:0] x_ext;
  logic [BM-1:0] result;
  logic [BM-1:0] rounded;
  logic [BM-1:0] scaled;
  logic [CTRL_W-1:0] ctrl_q;
  logic [RW-1:0] rate_q;
  logic [RW-1:0] pend_rate_q;
  logic [RW-1:0] rate_eff;
  logic [RW-1:0] phase_q;
  logic [RW-1:0] phase_eff;
  logic [RW-1:0] cfg_rate;
  logic [SHIFT_W-1:0] shift_q;
  logic [SHIFT_W-1:0] pend_shift_q;
  logic [SHIFT_W-1:0] sh;
  logic [CW-1:0] in_ch_q;
  logic [CW-1:0] emit_ch_q;
  logic [CW-1:0] ch_sel;
  logic [RW-1:0] emit_phase_q;
  emit_state_t state_q;
  logic pend_q;
  logic buf_valid;
  logic [IN_W-1:0] buf_data;
  logic ready_eff;
  logic out_free;
  logic take;
  logic apply_now;
  logic emit_go;
  logic produce;
  logic int_step;
  logic cfg_fire;
  logic [31:0] rd_word;
  logic addr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Input buffer
  // Input samples queue ahead
  sample_holder #(.W(IN_W), .DEPTH(BUF_DEPTH)) u_holder (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(s_data_tvalid),
    .in_ready(s_data_tready),
    .in_data(s_data_tdata),
    .out_valid(buf_valid),
    .out_ready(take),
    .out_data(buf_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flow control
  // Option off ignores ready
  assign ready_eff = m_data_tready || !ctrl_q[CTRL_BP_BIT];
  assign out_free = !m_data_tvalid || ready_eff;
  assign take = buf_valid && (MODE == DECIMATE ? out_free : state_q == ST_IDLE);
  assign emit_go = (MODE == INTERPOLATE) && state_q == ST_EMIT && out_free;
  assign apply_now = take && pend_q && in_ch_q == '0;
  assign rate_eff = apply_now ? pend_rate_q : rate_q;
  assign phase_eff = apply_now ? '0 : phase_q;
  assign produce = (MODE == DECIMATE) ? (take && phase_eff == rate_eff - RW'(1)) : emit_go;
  assign int_step = (MODE == DECIMATE) ? take : emit_go;
  assign ch_sel = (MODE == DECIMATE) ? in_ch_q : emit_ch_q;
  assign x_ext = BM'($signed(buf_data));

  ////////////////////////////////////////////////////////////////////////////
  // Stage masks
  for (genvar k = 0; k < 2*STAGES; k++) begin : g_mask
    localparam int DROP = (MODE == DECIMATE && !FULL) ?
                          ((BM - OUT_W) * (k + 1)) / (2*STAGES + 1) : 0;
    assign stage_mask[k] = {BM{1'b1}} << DROP;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Integrator and comb chains
  always_comb begin
    for (int j = 0; j < STAGES; j++) begin
      if (j == 0) begin
        if (MODE == DECIMATE) begin
          int_new[j] = (x_ext + integ_q[j][ch_sel]) & stage_mask[j];
        end else begin
          int_new[j] = ((emit_phase_q == '0 ? hold_q[emit_ch_q] : '0) +
                        integ_q[j][ch_sel]) & stage_mask[j];
        end
      end else begin
        int_new[j] = (int_new[j-1] + integ_q[j][ch_sel]) & stage_mask[j];
      end
    end
    for (int j = 0; j < STAGES; j++) begin
      if (j == 0) begin
        comb_in[j] = (MODE == DECIMATE) ? int_new[STAGES-1] : x_ext;
      end else begin
        comb_in[j] = comb_new[j-1];
      end
      comb_new[j] = (comb_in[j] - dly_q[j][in_ch_q][DIFF_DELAY-1]) &
                    stage_mask[STAGES+j];
    end
  end

  assign result = (MODE == DECIMATE) ? comb_new[STAGES-1] : int_new[STAGES-1];
  // Shift of the rate in force
  assign sh = (MODE == DECIMATE && apply_now) ? pend_shift_q : shift_q;

  always_comb begin
    rounded = result;
    if (ctrl_q[CTRL_ROUND_BIT] && !FULL && sh != '0) begin
      rounded = result + (BM'(1) << (sh - SHIFT_W'(1)));
    end
    scaled = BM'($signed(rounded) >>> sh);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Integrator state
  // Shared reset clears state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int j = 0; j < STAGES; j++) begin
        for (int c = 0; c < CHANNELS; c++) begin
          integ_q[j][c] <= '0;
        end
      end
    end else if (int_step) begin
      for (int j = 0; j < STAGES; j++) begin
        integ_q[j][ch_sel] <= int_new[j];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comb delays and interpolator hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int j = 0; j < STAGES; j++) begin
        for (int c = 0; c < CHANNELS; c++) begin
          for (int d = 0; d < DIFF_DELAY; d++) begin
            dly_q[j][c][d] <= '0;
          end
        end
      end
      for (int c = 0; c < CHANNELS; c++) begin
        hold_q[c] <= '0;
      end
    end else if ((MODE == DECIMATE) ? produce : take) begin
      for (int j = 0; j < STAGES; j++) begin
        dly_q[j][in_ch_q][0] <= comb_in[j];
        for (int d = 1; d < DIFF_DELAY; d++) begin
          dly_q[j][in_ch_q][d] <= dly_q[j][in_ch_q][d-1];
        end
      end
      hold_q[in_ch_q] <= comb_new[STAGES-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input channel and decimation phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_ch_q <= '0;
      phase_q <= '0;
    end else if (take) begin
      if (in_ch_q == CW'(CHANNELS - 1)) begin
        in_ch_q <= '0;
        phase_q <= (phase_eff == rate_eff - RW'(1)) ? '0 : phase_eff + RW'(1);
      end else begin
        in_ch_q <= in_ch_q + CW'(1);
        phase_q <= phase_eff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate configuration
  always_comb begin
    cfg_rate = s_cfg_tdata[RW-1:0];
    if (s_cfg_tdata < CFG_W'(RATE_MIN)) begin
      cfg_rate = RW'(RATE_MIN);
    end else if (s_cfg_tdata > CFG_W'(RATE_MAX)) begin
      cfg_rate = RW'(RATE_MAX);
    end
  end

  assign cfg_fire = s_cfg_tvalid && s_cfg_tready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_cfg_tready <= 1'b0;
      pend_q <= 1'b0;
      pend_rate_q <= RATE_RST;
      pend_shift_q <= SHIFT_RST;
      rate_q <= RATE_RST;
      shift_q <= SHIFT_RST;
    end else begin
      if (cfg_fire) begin
        pend_q <= 1'b1;
        pend_rate_q <= cfg_rate;
        pend_shift_q <= shift_for(cfg_rate);
        s_cfg_tready <= 1'b0;
      end else if (apply_now) begin
        pend_q <= 1'b0;
        s_cfg_tready <= 1'b1;
      end else begin
        s_cfg_tready <= !pend_q;
      end
      if (apply_now) begin
        rate_q <= pend_rate_q;
        shift_q <= pend_shift_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interpolator emission
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      emit_ch_q <= '0;
      emit_phase_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (MODE == INTERPOLATE && take && in_ch_q == CW'(CHANNELS - 1)) begin
            state_q <= ST_EMIT;
            emit_ch_q <= '0;
            emit_phase_q <= '0;
          end
        end
        ST_EMIT: begin
          if (emit_go) begin
            if (emit_ch_q == CW'(CHANNELS - 1)) begin
              emit_ch_q <= '0;
              if (emit_phase_q == rate_q - RW'(1)) begin
                state_q <= ST_IDLE;
              end else begin
                emit_phase_q <= emit_phase_q + RW'(1);
              end
            end else begin
              emit_ch_q <= emit_ch_q + CW'(1);
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stream
  // Held until accepted when backpressure on, else dropped after one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_data_tvalid <= 1'b0;
      m_data_tdata <= '0;
      m_data_tuser <= '0;
    end else if (produce) begin
      m_data_tvalid <= 1'b1;
      m_data_tdata <= scaled[OUT_W-1:0];
      m_data_tuser.first_channel_marker <= ch_sel == '0;
      m_data_tuser.channel_index_field <= CHAN_IDX_W'(ch_sel);
    end else if (ready_eff) begin
      m_data_tvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  always_comb begin
    addr_hit = 1'b1;
    rd_word = BUS_ZERO;
    case (paddr)
      CTRL_ADDR: begin
        rd_word = 32'(ctrl_q);
      end
      STATUS_ADDR: begin
        rd_word = 32'(rate_q);
        rd_word[STATUS_PEND_BIT] = pend_q;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= BUS_ZERO;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !addr_hit;
      prdata <= pwrite ? BUS_ZERO : rd_word;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (psel && penable && pready && pwrite && paddr == CTRL_ADDR) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end
endmodule
`default_nettype wire

// ==== cic_rate_change_filter_tb.sv ====
// Purpose: Self-checking bench for the CIC decimator
// Assumes: Full precision, RATE_MAX 16, DC input of 100
// Notes: Steady output is 100 times rate cubed
`timescale 1ns/1ps
`default_nettype none
module cic_rate_change_filter_tb
  import cic_pkg::*;
;
  localparam int OW = 28;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, send_en, stall;
  logic s_data_tvalid, s_data_tready, s_cfg_tvalid, s_cfg_tready, m_data_tvalid, m_data_tready;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rx_count, rx_gap, rd;
  logic [15:0] s_data_tdata, s_cfg_tdata, sample;
  logic [OW-1:0] m_data_tdata, rx_last;
  out_user_t m_data_tuser;
  int num_errors, cmp_count, old;
  int cyc = 0;
  int eff[3] = '{8, 16, 4};
  logic [15:0] cfg_v[3] = '{16'h0008, 16'h0064, 16'h0002};
  cic_rate_change_filter #(.OUT_W(OW), .RATE_MAX(16)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .s_data_tvalid(s_data_tvalid),
    .s_data_tready(s_data_tready), .s_data_tdata(s_data_tdata), .s_cfg_tvalid(s_cfg_tvalid),
    .s_cfg_tready(s_cfg_tready), .s_cfg_tdata(s_cfg_tdata), .m_data_tvalid(m_data_tvalid),
    .m_data_tready(m_data_tready), .m_data_tdata(m_data_tdata), .m_data_tuser(m_data_tuser));
  stream_partner #(.IN_W(16), .OUT_W(OW)) u_far (.clk(pclk), .rst_n(presetn),
    .send_en(send_en), .stall(stall), .sample(sample), .s_tvalid(s_data_tvalid),
    .s_tready(s_data_tready), .s_tdata(s_data_tdata), .m_tvalid(m_data_tvalid),
    .m_tready(m_data_tready), .m_tdata(m_data_tdata), .rx_count(rx_count),
    .rx_last(rx_last), .rx_gap(rx_gap));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  ////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg_send(input logic [15:0] v);
    @(posedge pclk);
    s_cfg_tvalid <= 1'b1;
    s_cfg_tdata <= v;
    do @(posedge pclk); while (s_cfg_tready !== 1'b1);
    s_cfg_tvalid <= 1'b0;
    s_cfg_tdata <= ~v;
  endtask
  task automatic wait_out(input int n);
    int t;
    t = rx_count + n;
    while (rx_count < t) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  ////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    s_cfg_tvalid = 1'b0;
    s_cfg_tdata = 16'h0;
    send_en = 1'b0;
    stall = 1'b0;
    sample = 16'h0064;
    num_errors = 0;
    cmp_count = 0;
    repeat (8) @(posedge pclk);
    chk(32'({s_data_tready, s_cfg_tready, m_data_tvalid, pready}), 32'h0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    $display("test reset done");
    apb(1'b1, CTRL_ADDR, 32'h3);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, CTRL_ADDR, 32'h0);
    apb(1'b1, STATUS_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("test registers done");
    send_en <= 1'b1;
    wait_out(6);
    chk(32'(rx_last), 32'(100 * 64));
    chk(rx_gap, 32'h4);
    old = 4;
    for (int i = 0; i < 3; i++) begin
      send_en <= 1'b0;
      repeat (8) @(posedge pclk);
      cfg_send(cfg_v[i]);
      @(posedge pclk);
      chk(32'(s_cfg_tready), 32'h0);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk(rd, 32'h0001_0000 + 32'(old));
      send_en <= 1'b1;
      wait_out(6);
      chk(32'(rx_last), 32'(100 * eff[i] * eff[i] * eff[i]));
      chk(rx_gap, 32'(eff[i]));
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk(rd, 32'(eff[i]));
      old = eff[i];
    end
    $display("test rate change done");
    apb(1'b1, CTRL_ADDR, 32'h2);
    stall <= 1'b1;
    while (s_data_tready !== 1'b0) @(posedge pclk);
    chk(32'({s_data_tready, m_data_tvalid}), 32'h1);
    wait_out(4);
    chk(32'(rx_last), 32'(100 * 64));
    $display("test backpressure done");
    stall <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'({s_data_tready, s_cfg_tready, m_data_tvalid, pready}), 32'h0);
    presetn <= 1'b1;
    wait_out(1);
    chk(32'(rx_last), 32'(100 * 20));
    $display("test mid reset done");
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== sample_holder.sv ====
// Purpose: Small input sample FIFO with registered ready and valid
// Assumes: DEPTH is a power of two, at least two
// Notes: Lets the sender run ahead of the filter engine
`timescale 1ns/1ps
`default_nettype none
module sample_holder #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic [PW:0] cnt_d;
  logic push;
  logic pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("sample_holder depth must be a power of two, at least two");
  end

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      in_ready <= cnt_d < (PW+1)'(DEPTH);
      out_valid <= cnt_d != '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + PW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + PW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ==== stream_partner.sv ====
// Purpose: Upstream sample source and downstream sink
// Assumes: One clock, single channel
// Notes: Sink can stall, ready once per eight cycles
`timescale 1ns/1ps
`default_nettype none
module stream_partner #(
  parameter int IN_W = 16,
  parameter int OUT_W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic send_en,
  input wire logic stall,
  input wire logic [IN_W-1:0] sample,
  output logic s_tvalid,
  input wire logic s_tready,
  output logic [IN_W-1:0] s_tdata,
  input wire logic m_tvalid,
  output logic m_tready,
  input wire logic [OUT_W-1:0] m_tdata,
  output logic [31:0] rx_count,
  output logic [OUT_W-1:0] rx_last,
  output logic [31:0] rx_gap
);
  logic [31:0] since_q;
  logic [2:0] tick_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_tvalid <= 1'b0;
    end else if (!s_tvalid || s_tready) begin
      s_tvalid <= send_en;
    end
  end
  assign s_tdata = s_tvalid ? sample : ~sample;
  assign m_tready = !stall || tick_q == 3'h0;
  ////////////////////////////////
  // take on valid and ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 3'h0;
      since_q <= 32'h0;
      rx_count <= 32'h0;
      rx_last <= '0;
      rx_gap <= 32'h0;
    end else begin
      tick_q <= tick_q + 3'h1;
      since_q <= since_q + 32'h1;
      if (m_tvalid && m_tready) begin
        rx_count <= rx_count + 32'h1;
        rx_last <= m_tdata;
        rx_gap <= since_q + 32'h1;
        since_q <= 32'h0;
      end
    end
  end
endmodule
`default_nettype wire
